// *** pkg/rtf_pkg.sv ***
// Purpose: Shared constants and decoders for the 8-bit reload timer with fine mode
// Assumes: APB with 32-bit data; printed offsets are word indices, byte address is four times the index
// Notes:   Each register is one aligned word; narrow data sits in the low bits
package rtf_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 32;

   // Register indices as printed, and their byte addresses
   localparam logic [15:0] IDX_CLK_SEL = 16'h4200;
   localparam logic [15:0] IDX_RELOAD  = 16'h4202;
   localparam logic [15:0] IDX_CTRL    = 16'h4206;
   localparam logic [ADDR_W-1:0] ADR_CLK_SEL = {IDX_CLK_SEL, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_RELOAD  = {IDX_RELOAD, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_CTRL    = {IDX_CTRL, 2'b00};

   // Register select codes
   typedef enum logic [1:0] {
      RTF_SEL_CLK  = 2'b00,
      RTF_SEL_RLD  = 2'b01,
      RTF_SEL_CTL  = 2'b10,
      RTF_SEL_NONE = 2'b11
   } rtf_sel_t;

   // Field positions in the control register, plus clock select and reload widths
   localparam int unsigned CTL_RUN_BIT    = 0;
   localparam int unsigned CTL_PRESET_BIT = 1;
   localparam int unsigned CTL_MODE_BIT   = 4;
   localparam int unsigned CTL_FINE_LSB   = 8;
   localparam int unsigned CTL_FINE_MSB   = 11;
   localparam int unsigned CLK_SEL_MSB    = 3;
   localparam int unsigned RELOAD_MSB     = 7;

   // Prescaler geometry and the reserved clock code
   localparam int unsigned NUM_TICKS    = 15;
   localparam logic [3:0]  CLK_SEL_RSVD = 4'hf;

   // Values after reset
   localparam logic [3:0] RST_CLK_SEL = 4'h0;
   localparam logic [7:0] RST_RELOAD  = 8'h00;
   localparam logic [7:0] RST_COUNT   = 8'h00;
   localparam logic [3:0] RST_FINE    = 4'h0;
   localparam logic       RST_MODE    = 1'b0;
   localparam logic       RST_RUN     = 1'b0;
   localparam logic [3:0] RST_UF_IDX  = 4'h0;

   // Count modes
   localparam logic MODE_REPEAT  = 1'b0;
   localparam logic MODE_ONESHOT = 1'b1;

   // Address decode, shared by read and write paths
   function automatic rtf_sel_t rtf_decode(input logic [ADDR_W-1:0] addr);
      rtf_sel_t s;
      s = RTF_SEL_NONE;
      if (addr == ADR_CLK_SEL) begin
         s = RTF_SEL_CLK;
      end else if (addr == ADR_RELOAD) begin
         s = RTF_SEL_RLD;
      end else if (addr == ADR_CTRL) begin
         s = RTF_SEL_CTL;
      end
      return s;
   endfunction : rtf_decode

   // Position of an underflow (0 = first of 16) in the cumulative delay order; 0 means never
   function automatic logic [3:0] rtf_rank(input logic [3:0] idx);
      logic [3:0] k;
      k = 4'h0;
      case (idx)
         4'hf:    k = 4'h1;
         4'h7:    k = 4'h2;
         4'hb:    k = 4'h3;
         4'h3:    k = 4'h4;
         4'hd:    k = 4'h5;
         4'h5:    k = 4'h6;
         4'h9:    k = 4'h7;
         4'h1:    k = 4'h8;
         4'he:    k = 4'h9;
         4'h6:    k = 4'ha;
         4'ha:    k = 4'hb;
         4'h2:    k = 4'hc;
         4'hc:    k = 4'hd;
         4'h4:    k = 4'he;
         4'h8:    k = 4'hf;
         default: k = 4'h0;
      endcase
      return k;
   endfunction : rtf_rank

   // True when this underflow is deferred by one count clock under the given pattern
   function automatic logic rtf_delayed(input logic [3:0] idx, input logic [3:0] fine);
      logic [3:0] k;
      k = rtf_rank(idx);
      return (k != 4'h0) && (k <= fine);
   endfunction : rtf_delayed

endpackage : rtf_pkg

// *** verilog/rtf_tick_sel.sv ***
// Purpose: Picks the count-clock enable from the prescaler tick strobes
// Assumes: Tick strobes are one-cycle enables made on the same clock
// Notes:   The reserved code yields no tick, so a timer left on it never counts
`timescale 1ns/100ps
module rtf_tick_sel
   import rtf_pkg::*;
(
   // Prescaler strobes, bit n is the clock divided by 2^n
   input  wire logic [rtf_pkg::NUM_TICKS-1:0] ticks,
   // Selection
   input  wire logic [3:0]                    sel,
   // Chosen enable
   output logic                               tick
);

   // Plain multiplexer, reserved code blocked
   always_comb begin
      tick = 1'b0;
      if (sel != CLK_SEL_RSVD) begin
         tick = ticks[sel];  // see [R4]
      end
   end

endmodule : rtf_tick_sel

// *** verilog/rtf_timer.sv ***
// Purpose: 8-bit presettable reload down timer with repeat, one-shot and fine baud modes
// Assumes: APB slave, one clock; prescaler strobes arrive on the same clock
// Notes:   Underflow pulse feeds both the serial port and the interrupt controller
//
// Function
// [R1] Repeat mode reloads at every underflow and keeps counting until run is cleared.
// [R2] One-shot mode reloads at underflow then stops by itself.
// [R3] Software changes the count mode only while stopped.
// [R4] Count clock is prescaler output two to the n; code 0xf reserved; default 0.
// [R5] Software runs the prescaler first and changes clock select only while stopped.
// [R6] Reload value is copied into the counter on preset and on underflow.
// [R7] Without delays the underflow period is reload plus one count clocks.
// [R8] Writing one to the preset bit loads the reload value.
// [R9] Writing one to run starts counting from whatever the counter holds.
// [R10] Underflow gives a pulse, a reload and an interrupt request together.
// [R11] Writing zero to run halts; the counter holds its value.
// [R12] Preset while running reloads without stopping.
// [R13] Underflow pulses go to the serial port which divides by sixteen.
// [R14] Bit rate is count clock over reload plus one times sixteen plus pattern.
// [R15] Fine pattern in control bits 11 to 8 picks delayed underflows of sixteen.
// [R16] Each delay adds exactly one count clock, interrupt delayed alike.
// [R17] Pattern n delays underflows in fixed cumulative order; underflow one never.
// [R18] Fine pattern resets to zero, which inserts no delays.
// [R19] Software sets mode, clock, reload, preset and interrupt before writing run.
// [R20] Counter decrements on each tick while running; zero on a tick is underflow.
`timescale 1ns/100ps
module rtf_timer
   import rtf_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                        CLOCK,
   input  wire logic                        RST,
   input  wire logic                        CE,
   // APB slave
   input  wire logic                        PSEL,
   input  wire logic                        PENABLE,
   input  wire logic                        PWRITE,
   input  wire logic [rtf_pkg::ADDR_W-1:0]  PADDR,
   input  wire logic [rtf_pkg::DATA_W-1:0]  PWDATA,
   output logic      [rtf_pkg::DATA_W-1:0]  PRDATA,
   output logic                             PREADY,
   output logic                             PSLVERR,
   // Prescaler strobes
   input  wire logic [rtf_pkg::NUM_TICKS-1:0] PRESCALE_TICKS,
   // Underflow outputs and run state
   output logic                             UART_CLK_PULSE,
   output logic                             IRQ_REQ,
   output logic                             RUNNING
);

   // All state of the block
   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
      logic [3:0]        clk_sel;
      logic [7:0]        reload;
      logic [3:0]        fine;
      logic              mode;
      logic              run;
      logic [7:0]        cnt;
      logic              stall;
      logic [3:0]        uf_idx;
      logic              uf_pulse;
   } rtf_state_t;

   rtf_state_t st_r;
   rtf_state_t st_nxt;
   logic       tick;
   logic       acc;
   logic       wr;
   rtf_sel_t   sel_setup;
   rtf_sel_t   sel_acc;
   logic       preset_wr;

   // Count-clock selection
   rtf_tick_sel u_tick_sel (
      .ticks (PRESCALE_TICKS),
      .sel   (st_r.clk_sel),
      .tick  (tick)
   );

   // Bus phase decode; access completes only while ready is high
   assign acc       = PSEL && PENABLE && st_r.pready;
   assign wr        = acc && PWRITE;
   assign sel_setup = rtf_decode(PADDR);
   assign sel_acc   = rtf_decode(PADDR);
   assign preset_wr = wr && (sel_acc == RTF_SEL_CTL) && PWDATA[CTL_PRESET_BIT];

   // Next state: counting first, bus writes override the fields they touch
   always_comb begin
      st_nxt          = st_r;
      st_nxt.uf_pulse = 1'b0;
      st_nxt.pready   = 1'b0;
      st_nxt.pslverr  = 1'b0;

      // Counting only on a selected tick while running
      if (st_r.run && tick) begin  // see [R20]
         if (st_r.stall) begin
            // Deferred underflow released one count clock late
            st_nxt.stall    = 1'b0;  // see [R16]
            st_nxt.uf_pulse = 1'b1;  // see [R10]
            st_nxt.cnt      = st_r.reload;  // see [R6]
            st_nxt.uf_idx   = st_r.uf_idx + 4'h1;
            if (st_r.mode == MODE_ONESHOT) begin
               st_nxt.run = 1'b0;  // see [R2]
            end
         end else if (st_r.cnt == 8'h00) begin
            if (rtf_delayed(st_r.uf_idx, st_r.fine)) begin
               // Hold at zero for one extra count clock
               st_nxt.stall = 1'b1;  // see [R15] see [R17]
            end else begin
               st_nxt.uf_pulse = 1'b1;  // see [R10] see [R13]
               st_nxt.cnt      = st_r.reload;  // see [R1] see [R6] see [R7]
               st_nxt.uf_idx   = st_r.uf_idx + 4'h1;
               if (st_r.mode == MODE_ONESHOT) begin
                  st_nxt.run = 1'b0;  // see [R2]
               end
            end
         end else begin
            st_nxt.cnt = st_r.cnt - 8'h01;  // see [R20]
         end
      end

      // Setup cycle: answer is prepared so ready is high in the first access cycle
      if (PSEL && !PENABLE) begin
         st_nxt.pready  = 1'b1;
         st_nxt.pslverr = (sel_setup == RTF_SEL_NONE);
         st_nxt.prdata  = '0;
         unique case (sel_setup)
            RTF_SEL_CLK: st_nxt.prdata[CLK_SEL_MSB:0] = st_r.clk_sel;
            RTF_SEL_RLD: st_nxt.prdata[RELOAD_MSB:0]  = st_r.reload;
            RTF_SEL_CTL: begin
               // Preset bit always reads zero; run shows the live state
               st_nxt.prdata[CTL_FINE_MSB:CTL_FINE_LSB] = st_r.fine;
               st_nxt.prdata[CTL_MODE_BIT]              = st_r.mode;
               st_nxt.prdata[CTL_RUN_BIT]               = st_r.run;
            end
            RTF_SEL_NONE: st_nxt.prdata = '0;
         endcase
      end

      // Writes take effect at the completing access edge
      if (wr) begin
         unique case (sel_acc)
            RTF_SEL_CLK: st_nxt.clk_sel = PWDATA[CLK_SEL_MSB:0];  // see [R4]
            RTF_SEL_RLD: st_nxt.reload  = PWDATA[RELOAD_MSB:0];
            RTF_SEL_CTL: begin
               st_nxt.fine = PWDATA[CTL_FINE_MSB:CTL_FINE_LSB];  // see [R15]
               st_nxt.mode = PWDATA[CTL_MODE_BIT];
               st_nxt.run  = PWDATA[CTL_RUN_BIT];  // see [R9] see [R11]
            end
            RTF_SEL_NONE: st_nxt.run = st_r.run;
         endcase
      end

      // Preset beats counting and restarts the fine pattern; run is left as written
      if (preset_wr) begin
         st_nxt.cnt      = st_r.reload;  // see [R8] see [R12]
         st_nxt.stall    = 1'b0;
         st_nxt.uf_idx   = RST_UF_IDX;
         st_nxt.uf_pulse = 1'b0;
      end
   end

   // State register; enable low freezes everything, pulses included
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_r          <= '0;
         st_r.clk_sel  <= RST_CLK_SEL;
         st_r.reload   <= RST_RELOAD;
         st_r.fine     <= RST_FINE;  // see [R18]
         st_r.mode     <= RST_MODE;
         st_r.run      <= RST_RUN;
         st_r.cnt      <= RST_COUNT;
         st_r.uf_idx   <= RST_UF_IDX;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign PRDATA         = st_r.prdata;
   assign PREADY         = st_r.pready;
   assign PSLVERR        = st_r.pslverr;
   assign UART_CLK_PULSE = st_r.uf_pulse;  // see [R13] see [R14]
   assign IRQ_REQ        = st_r.uf_pulse;  // see [R10]
   assign RUNNING        = st_r.run;

   // Checks on the counting engine and the bus interface

   property p_oneshot_stop;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && $past(st_nxt.uf_pulse) && $past(st_r.mode) && !$past(wr) |-> !st_r.run;
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop)  // see [R2]
      else $error("one-shot timer still running after underflow");

   property p_repeat_keeps_run;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && $past(st_nxt.uf_pulse) && !$past(st_r.mode) && !$past(wr) |-> st_r.run;
   endproperty
   a_repeat_keeps_run: assert property (p_repeat_keeps_run)  // see [R1]
      else $error("repeat timer stopped at underflow");

   property p_reload_on_uf;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && st_r.uf_pulse && !$past(preset_wr) |-> st_r.cnt == $past(st_r.reload);
   endproperty
   a_reload_on_uf: assert property (p_reload_on_uf)  // see [R6]
      else $error("counter not reloaded at underflow");

   property p_decrement;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && $past(st_r.run) && $past(tick) && $past(st_r.cnt) != 8'h00 && !$past(preset_wr)
      |-> st_r.cnt == $past(st_r.cnt) - 8'h01;
   endproperty
   a_decrement: assert property (p_decrement)  // see [R20]
      else $error("counter did not step down on a tick");

   property p_stop_hold;
      @(posedge CLOCK) disable iff (RST)
      !st_r.run && !preset_wr |=> $stable(st_r.cnt);
   endproperty
   a_stop_hold: assert property (p_stop_hold)  // see [R11]
      else $error("stopped counter changed");

   property p_preset_run;
      @(posedge CLOCK) disable iff (RST)
      CE && preset_wr && PWDATA[CTL_RUN_BIT] |=> st_r.run && st_r.cnt == $past(st_r.reload);
   endproperty
   a_preset_run: assert property (p_preset_run)  // see [R12]
      else $error("preset while running did not reload and keep running");

   property p_first_never_delayed;
      @(posedge CLOCK) disable iff (RST)
      st_r.stall |-> st_r.uf_idx != 4'h0 && st_r.cnt == 8'h00;
   endproperty
   a_first_never_delayed: assert property (p_first_never_delayed)  // see [R17]
      else $error("first underflow of the group was delayed");

   property p_no_fine_no_stall;
      @(posedge CLOCK) disable iff (RST)
      $past(st_r.fine) == 4'h0 && !$past(st_r.stall) |-> !st_r.stall;
   endproperty
   a_no_fine_no_stall: assert property (p_no_fine_no_stall)  // see [R18]
      else $error("delay inserted with fine pattern zero");

   property p_stall_one_tick;
      @(posedge CLOCK) disable iff (RST)
      CE && st_r.stall && st_r.run && tick && !preset_wr |=> st_r.uf_pulse && !st_r.stall;
   endproperty
   a_stall_one_tick: assert property (p_stall_one_tick)  // see [R16]
      else $error("deferred underflow not released on the next tick");

   property p_rsvd_no_tick;
      @(posedge CLOCK) disable iff (RST)
      st_r.clk_sel == CLK_SEL_RSVD |-> !tick;
   endproperty
   a_rsvd_no_tick: assert property (p_rsvd_no_tick)  // see [R4]
      else $error("count tick taken on the reserved clock code");

   property p_tick_select;
      @(posedge CLOCK) disable iff (RST)
      st_r.clk_sel != CLK_SEL_RSVD |-> tick == PRESCALE_TICKS[st_r.clk_sel];
   endproperty
   a_tick_select: assert property (p_tick_select)  // see [R4]
      else $error("count tick does not follow the selected strobe");

   property p_preset_load;
      @(posedge CLOCK) disable iff (RST)
      CE && preset_wr |=> st_r.cnt == $past(st_r.reload) && !st_r.uf_pulse && !st_r.stall;
   endproperty
   a_preset_load: assert property (p_preset_load)  // see [R8]
      else $error("preset did not load the reload value");

   property p_run_written;
      @(posedge CLOCK) disable iff (RST)
      CE && wr && sel_acc == RTF_SEL_CTL |=> st_r.run == $past(PWDATA[CTL_RUN_BIT]);
   endproperty
   a_run_written: assert property (p_run_written)  // see [R9]
      else $error("run state differs from the written bit");

   property p_fine_written;
      @(posedge CLOCK) disable iff (RST)
      CE && wr && sel_acc == RTF_SEL_CTL
      |=> st_r.fine == $past(PWDATA[CTL_FINE_MSB:CTL_FINE_LSB]) && st_r.mode == $past(PWDATA[CTL_MODE_BIT]);
   endproperty
   a_fine_written: assert property (p_fine_written)  // see [R15]
      else $error("fine pattern or mode differs from the written field");

   property p_uf_from_zero;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && st_r.uf_pulse |-> $past(st_r.run) && $past(tick) && $past(st_r.cnt) == 8'h00;
   endproperty
   a_uf_from_zero: assert property (p_uf_from_zero)  // see [R20]
      else $error("underflow pulse without a tick at zero");

   property p_hold_no_tick;
      @(posedge CLOCK) disable iff (RST)
      CE && !tick && !preset_wr |=> $stable(st_r.cnt) && !st_r.uf_pulse;
   endproperty
   a_hold_no_tick: assert property (p_hold_no_tick)  // see [R20]
      else $error("counter moved without a tick");

   property p_idx_advance;
      @(posedge CLOCK) disable iff (RST)
      $past(CE) && st_r.uf_pulse |-> st_r.uf_idx == $past(st_r.uf_idx) + 4'h1;
   endproperty
   a_idx_advance: assert property (p_idx_advance)  // see [R17]
      else $error("underflow index did not advance with the pulse");

   // Underflow sixteen is the first to be deferred by any nonzero pattern
   property p_delay_taken;
      @(posedge CLOCK) disable iff (RST)
      CE && st_r.run && tick && !st_r.stall && st_r.cnt == 8'h00 && !preset_wr
      && st_r.uf_idx == 4'hf && st_r.fine != 4'h0 |=> st_r.stall && !st_r.uf_pulse;
   endproperty
   a_delay_taken: assert property (p_delay_taken)  // see [R16]
      else $error("last underflow of the group not deferred");

   property p_pready_one;
      @(posedge CLOCK) disable iff (RST)
      CE && st_r.pready && !(PSEL && !PENABLE) |=> !st_r.pready;
   endproperty
   a_pready_one: assert property (p_pready_one)  // Bus answer stands one cycle
      else $error("bus ready held longer than one cycle");

   property p_mapped_ok;
      @(posedge CLOCK) disable iff (RST)
      CE && PSEL && !PENABLE && (PADDR == ADR_CLK_SEL || PADDR == ADR_RELOAD || PADDR == ADR_CTRL)
      |=> st_r.pready && !st_r.pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok)  // Mapped words answer cleanly
      else $error("mapped register answered with an error");

   property p_rsvd_read_zero;
      @(posedge CLOCK) disable iff (RST)
      st_r.pready |-> st_r.prdata[DATA_W-1:CTL_FINE_MSB+1] == '0;
   endproperty
   a_rsvd_read_zero: assert property (p_rsvd_read_zero)  // Reserved bits read zero
      else $error("reserved read bits not zero");

   // Main scenarios
   c_repeat_uf:  cover property (@(posedge CLOCK) disable iff (RST) st_r.uf_pulse && !st_r.mode);
   c_oneshot:    cover property (@(posedge CLOCK) disable iff (RST) st_r.uf_pulse && st_r.mode);
   c_fine_stall: cover property (@(posedge CLOCK) disable iff (RST) st_r.stall ##[1:300] st_r.uf_pulse);
   c_preset_run: cover property (@(posedge CLOCK) disable iff (RST) preset_wr && st_r.run);

endmodule : rtf_timer

// *** bench/rtf_uart_model.sv ***
// Purpose: Far-side model of the serial port divider and the interrupt flag
// Assumes: Timer pulses are one-cycle strobes on CLOCK
// Notes:   Only counts; no shifting of serial bits is modelled
`timescale 1ns/100ps
module rtf_uart_model (
   // Clock and reset
   input  wire logic CLOCK,
   input  wire logic RST,
   // Timer outputs
   input  wire logic UART_CLK_PULSE,
   input  wire logic IRQ_REQ,
   // Observed results
   output logic [3:0] div_r,
   output int         samp_cnt,
   output int         irq_cnt
);
   // Sampling clock every sixteenth pulse; every request latches a flag count
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         div_r    <= 4'h0;
         samp_cnt <= 0;
         irq_cnt  <= 0;
      end else begin
         if (UART_CLK_PULSE) begin
            div_r <= div_r + 4'h1;
         end
         if (UART_CLK_PULSE && div_r == 4'hf) begin
            samp_cnt <= samp_cnt + 1;
         end
         if (IRQ_REQ) begin
            irq_cnt <= irq_cnt + 1;
         end
      end
   end
endmodule : rtf_uart_model

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the reload timer with fine mode
// Assumes: Zero-wait APB answers; registered outputs read at the rising edge
// Notes:   Prescaler strobes come from a free counter so every code is reachable
`timescale 1ns/100ps
module tb_top;
   import rtf_pkg::*;
   // Stimulus and responses
   logic                 CLOCK = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [ADDR_W-1:0]    PADDR = '0;
   logic [DATA_W-1:0]    PWDATA = '0;
   logic [DATA_W-1:0]    PRDATA, rd;
   logic                 PREADY, PSLVERR, UART_CLK_PULSE, IRQ_REQ, RUNNING, er;
   logic [NUM_TICKS-1:0] tk = '0;
   logic [13:0]          pc = '0;
   logic [3:0]           div_r;
   int                   samp_cnt, irq_cnt, cyc = 0, bad_count = 0, n_compared = 0;
   int                   ord [15] = '{16, 8, 12, 4, 14, 6, 10, 2, 15, 7, 11, 3, 13, 5, 9};

   always #12.5 CLOCK = ~CLOCK;

   // Prescaler: bit n strobes once every 2^n cycles, code 14 wraps the counter
   always @(posedge CLOCK) begin
      pc <= pc + 14'h1;
      for (int n = 0; n < NUM_TICKS; n++) begin
         tk[n] <= ((pc + 14'h1) & ((14'h1 << n) - 14'h1)) == 14'h0;
      end
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         summarize();
      end
   end

   rtf_timer rtf_timer_inst (.CLOCK(CLOCK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .PRESCALE_TICKS(tk), .UART_CLK_PULSE(UART_CLK_PULSE),
      .IRQ_REQ(IRQ_REQ), .RUNNING(RUNNING));
   rtf_uart_model rtf_uart_model_inst (.CLOCK(CLOCK), .RST(RST), .UART_CLK_PULSE(UART_CLK_PULSE),
      .IRQ_REQ(IRQ_REQ), .div_r(div_r), .samp_cnt(samp_cnt), .irq_cnt(irq_cnt));

   // One compare, counted; four-state so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // APB transfer; held until PREADY is seen high at a rising edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   function automatic logic [31:0] ctl(input logic [3:0] f, input logic m, input logic p, input logic r);
      return {20'h0, f, 3'h0, m, 2'h0, p, r};
   endfunction : ctl

   // Edge count at the next pulse
   task automatic wait_pulse(output int t);
      do begin
         @(posedge CLOCK);
      end while (UART_CLK_PULSE !== 1'b1);
      t = cyc;
   endtask : wait_pulse

   // No pulse may appear for n cycles
   task automatic quiet(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge CLOCK);
         if (UART_CLK_PULSE !== 1'b0) hits++;
      end
      chk(32'(hits), 32'h0);
   endtask : quiet

   // Reset values, reserved bits, write-only preset and an unmapped word
   task automatic t_regs();
      rdc(ADR_CLK_SEL, 32'h0);
      rdc(ADR_RELOAD, 32'h0);
      rdc(ADR_CTRL, 32'h0);
      apb(1'b0, ADR_CTRL + 18'h4, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      wr(ADR_RELOAD, 32'h1a5);
      rdc(ADR_RELOAD, 32'ha5);
      wr(ADR_CTRL, ctl(4'h5, 1'b1, 1'b1, 1'b0));
      rdc(ADR_CTRL, 32'h510);
      wr(ADR_CTRL, 32'h0);
   endtask : t_regs

   // Repeat periods over clock codes and reload boundaries, then the reserved code
   task automatic t_period();
      logic [3:0] s [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
      logic [7:0] r [5] = '{8'hff, 8'h01, 8'h01, 8'h02, 8'h00};
      int         t0, t1;
      for (int i = 0; i < 5; i++) begin
         wr(ADR_CLK_SEL, 32'(s[i]));
         wr(ADR_RELOAD, 32'(r[i]));
         wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b1, 1'b1));
         wait_pulse(t0);
         wait_pulse(t1);
         chk(32'(t1 - t0), (32'(r[i]) + 32'h1) << s[i]);
         wr(ADR_CTRL, 32'h0);
      end
      wr(ADR_CLK_SEL, 32'hf);
      wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b1, 1'b1));
      quiet(200);
      wr(ADR_CTRL, 32'h0);
      wr(ADR_CLK_SEL, 32'h0);
   endtask : t_period

   // One-shot gives a single pulse and clears run
   task automatic t_oneshot();
      int t0;
      wr(ADR_RELOAD, 32'h5);
      wr(ADR_CTRL, ctl(4'h0, 1'b1, 1'b1, 1'b1));
      wait_pulse(t0);
      quiet(40);
      chk({31'h0, RUNNING}, 32'h0);
      rdc(ADR_CTRL, 32'h10);
      wr(ADR_CTRL, 32'h0);
   endtask : t_oneshot

   // Stop holds the count; restart without preset finishes the remainder
   task automatic t_stop();
      int s, w, w2, s2;
      wr(ADR_RELOAD, 32'h7);
      wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b1, 1'b1));
      wait_pulse(s);
      wr(ADR_CTRL, 32'h0);
      w = cyc;
      quiet(30);
      chk({31'h0, RUNNING}, 32'h0);
      wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b0, 1'b1));
      w2 = cyc;
      wait_pulse(s2);
      chk(32'(s2 - w2), 32'(8 - (w - s)));
      wr(ADR_CTRL, 32'h0);
   endtask : t_stop

   // Preset while running reloads and keeps run; enable low freezes the count
   task automatic t_preset();
      int s, w;
      wr(ADR_RELOAD, 32'h7);
      wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b1, 1'b1));
      wait_pulse(s);
      wr(ADR_CTRL, ctl(4'h0, 1'b0, 1'b1, 1'b1));
      w = cyc;
      CE <= 1'b0;
      repeat (3) @(posedge CLOCK);
      CE <= 1'b1;
      wait_pulse(s);
      chk(32'(s - w), 32'h7 + 32'h2 + 32'h3);
      chk({31'h0, RUNNING}, 32'h1);
      wr(ADR_CTRL, 32'h0);
   endtask : t_preset

   // Every fine pattern: per-underflow periods, group sum, divider and requests
   task automatic t_fine();
      int   t0, t1, sum, i0, s0;
      logic dly;
      wr(ADR_RELOAD, 32'h0);
      for (int f = 0; f < 16; f++) begin
         wr(ADR_CTRL, ctl(4'(f), 1'b0, 1'b1, 1'b1));
         wait_pulse(t0);
         sum = 0;
         i0 = irq_cnt;
         s0 = samp_cnt;
         for (int j = 2; j <= 17; j++) begin
            dly = 1'b0;
            for (int k = 0; k < f; k++) if (ord[k] == j) dly = 1'b1;
            wait_pulse(t1);
            chk(32'(t1 - t0), 32'h1 + 32'(dly));
            sum += t1 - t0;
            t0 = t1;
         end
         chk(32'(sum), 32'(16 + f));
         chk(32'(irq_cnt - i0), 32'h10);
         chk(32'(samp_cnt - s0), 32'h1);
         wr(ADR_CTRL, 32'h0);
      end
   endtask : t_fine

   // Counts, verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // Main sequence
   initial begin
      repeat (20) @(posedge CLOCK);
      RST <= 1'b0;
      t_regs();
      t_period();
      t_oneshot();
      t_stop();
      t_preset();
      t_fine();
      summarize();
   end
endmodule : tb_top
